// [shared/dsq_pkg.sv]
// package: constants and types for the converter frame sequencer host
package dsq_pkg;

  // ----------------------------------------------------------------
  // clock and frame shape
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int FRAME_BITS = 24;
  localparam int FRAME_BITS_CRC = 32;
  localparam int WORD_W = 32;
  localparam int CNT_W = 16;
  localparam int BITCNT_W = 6;
  // sclk half period in system clocks; 4 gives 80 ns, a 160 ns period, above the 120 ns read minimum
  localparam int SCLK_HALF_CYC = 4;

  // ----------------------------------------------------------------
  // times as printed, in ns, or in us where the name ends in _US
  // ----------------------------------------------------------------
  localparam int T_SYNC_SETUP_NS = 33;
  localparam int T_SYNC_HOLD_NS = 10;
  localparam int T_GAP_ANY_NS = 500;
  localparam int T_GAP_CODE_NS = 1500;
  localparam int T_GAP_RANGE_US = 500;
  localparam int T_LOAD_BEFORE_NS = 750;
  localparam int T_LOAD_AFTER_NS = 1500;
  localparam int T_LOAD_LOW_NS = 250;
  localparam int T_RESP_FAST_NS = 600;
  localparam int T_RESP_SLEW_NS = 2000;
  localparam int T_RESP_TIED_NS = 1500;
  localparam int T_RST_LOW_US = 5;
  localparam int T_RST_WAIT_US = 100;

  // ----------------------------------------------------------------
  // cycle counts: least times round up, longest times round down
  // ----------------------------------------------------------------
  localparam int SYNC_SETUP_CYC = (T_SYNC_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_HOLD_CYC = (T_SYNC_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_ANY_CYC = (T_GAP_ANY_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_CODE_CYC = (T_GAP_CODE_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_RANGE_CYC = T_GAP_RANGE_US * CLK_MHZ;
  localparam int LOAD_BEFORE_CYC = (T_LOAD_BEFORE_NS * CLK_MHZ + 999) / 1000;
  localparam int LOAD_AFTER_CYC = (T_LOAD_AFTER_NS * CLK_MHZ + 999) / 1000;
  localparam int LOAD_LOW_CYC = (T_LOAD_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int RESP_FAST_CYC = (T_RESP_FAST_NS * CLK_MHZ) / 1000;
  localparam int RESP_SLEW_CYC = (T_RESP_SLEW_NS * CLK_MHZ) / 1000;
  localparam int RESP_TIED_CYC = (T_RESP_TIED_NS * CLK_MHZ) / 1000;
  localparam int RST_LOW_CYC = T_RST_LOW_US * CLK_MHZ;
  localparam int RST_WAIT_CYC = T_RST_WAIT_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // command types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_OTHER = 2'h0,
    KIND_CODE = 2'h1,
    KIND_RANGE = 2'h2
  } dsq_kind_t;

  typedef enum logic [1:0] {
    LOAD_NONE = 2'h0,
    LOAD_IN_FRAME = 2'h1,
    LOAD_AFTER = 2'h2,
    LOAD_TIED = 2'h3
  } dsq_load_t;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic crc_en;
    logic slew_en;
    dsq_kind_t kind;
    dsq_load_t load;
  } dsq_cmd_t;

endpackage : dsq_pkg

// [rtl/dsq_sclk_gen.sv]
// serial clock divider with rise and fall event pulses
`timescale 1ns/1ps
module dsq_sclk_gen #(
  parameter int HALF_CYC = dsq_pkg::SCLK_HALF_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run,
  output logic o_sclk,
  output logic o_fall,
  output logic o_rise
);
  import dsq_pkg::*;

  logic [CNT_W-1:0] div_r;
  logic [CNT_W-1:0] div_nxt;
  logic sclk_r;
  logic sclk_nxt;
  logic wrap;

  assign wrap = (div_r == CNT_W'(HALF_CYC - 1));

  always_comb begin
    div_nxt = div_r;
    sclk_nxt = sclk_r;
    if (!i_run) begin
      // idles high so the first edge of a frame is a falling one
      div_nxt = '0;
      sclk_nxt = 1'b1;
    end else if (wrap) begin
      div_nxt = '0;
      sclk_nxt = ~sclk_r;
    end else begin
      div_nxt = div_r + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_r <= '0;
      sclk_r <= 1'b1;
    end else begin
      div_r <= div_nxt;
      sclk_r <= sclk_nxt;
    end
  end

  assign o_sclk = sclk_r;
  assign o_fall = i_run && wrap && sclk_r;
  assign o_rise = i_run && wrap && !sclk_r;

endmodule : dsq_sclk_gen

// [rtl/dsq_host.sv]
// host controller sequencing serial frames, load strobe and reset for the converter
`timescale 1ns/1ps
module dsq_host #(
  parameter int RANGE_GAP_CYC = dsq_pkg::GAP_RANGE_CYC,
  parameter int RST_WAIT_CYC = dsq_pkg::RST_WAIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire dsq_pkg::dsq_cmd_t i_cmd,
  input wire logic i_hw_reset,
  input wire logic i_sdo,
  output logic o_ready,
  output logic o_done,
  output logic [dsq_pkg::WORD_W-1:0] o_rdata,
  output logic o_sclk,
  output logic o_sdi,
  output logic o_sync_n,
  output logic o_output_load_strobe_n,
  output logic o_reset_n
);
  import dsq_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_RST_LOW = 7'h01,
    ST_RST_WAIT = 7'h02,
    ST_IDLE = 7'h04,
    ST_SETUP = 7'h08,
    ST_SHIFT = 7'h10,
    ST_TAIL = 7'h20,
    ST_GAP = 7'h40
  } dsq_state_t;

  dsq_state_t st_r, st_nxt;
  dsq_cmd_t cmd_r, cmd_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [BITCNT_W-1:0] bits_r, bits_nxt;
  logic [WORD_W-1:0] tx_r, tx_nxt;
  logic [WORD_W-1:0] rx_r, rx_nxt;
  logic [WORD_W-1:0] rdata_r, rdata_nxt;
  logic done_r, done_nxt;
  logic sync_n_r, sync_n_nxt;
  logic strobe_n_r, strobe_n_nxt;
  logic reset_n_r, reset_n_nxt;
  logic sdo_meta_r, sdo_sync_r;
  logic sclk_run, sclk_fall, sclk_rise;
  logic [BITCNT_W-1:0] frame_bits;
  logic [CNT_W-1:0] gap_need;

  function automatic logic [CNT_W-1:0] max16(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
    max16 = (a > b) ? a : b;
  endfunction : max16

  // idle time needed after sync rises, including strobe and device response
  function automatic logic [CNT_W-1:0] gap_cycles(input dsq_cmd_t c);
    logic [CNT_W-1:0] g;
    logic [CNT_W-1:0] resp;
    g = CNT_W'(GAP_ANY_CYC);
    resp = c.slew_en ? CNT_W'(RESP_SLEW_CYC) : CNT_W'(RESP_FAST_CYC);
    if (c.kind == KIND_CODE) begin
      g = CNT_W'(GAP_CODE_CYC);
    end else if (c.kind == KIND_RANGE) begin
      g = CNT_W'(RANGE_GAP_CYC);
    end
    unique case (c.load)
      LOAD_AFTER: begin
        g = max16(g, CNT_W'(LOAD_AFTER_CYC) + max16(resp, CNT_W'(LOAD_LOW_CYC)));
      end
      LOAD_IN_FRAME: begin
        // strobe fell LOAD_BEFORE_CYC before sync rose
        if (resp > CNT_W'(LOAD_BEFORE_CYC)) begin
          g = max16(g, resp - CNT_W'(LOAD_BEFORE_CYC));
        end
      end
      LOAD_TIED: begin
        g = max16(g, CNT_W'(RESP_TIED_CYC));
      end
      LOAD_NONE: begin
        g = g;
      end
    endcase
    gap_cycles = g;
  endfunction : gap_cycles

  // ----------------------------------------------------------------
  // serial clock and sdo synchroniser
  // ----------------------------------------------------------------
  assign sclk_run = (st_r == ST_SHIFT);

  dsq_sclk_gen #(
    .HALF_CYC(SCLK_HALF_CYC)
  ) u_sclk (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(sclk_run),
    .o_sclk(o_sclk),
    .o_fall(sclk_fall),
    .o_rise(sclk_rise)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sdo_meta_r <= 1'b0;
      sdo_sync_r <= 1'b0;
    end else begin
      sdo_meta_r <= i_sdo;
      sdo_sync_r <= sdo_meta_r;
    end
  end

  assign frame_bits = cmd_r.crc_en ? BITCNT_W'(FRAME_BITS_CRC) : BITCNT_W'(FRAME_BITS);
  assign gap_need = gap_cycles(cmd_r);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    cnt_nxt = cnt_r + CNT_W'(1);
    bits_nxt = bits_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    rdata_nxt = rdata_r;
    done_nxt = 1'b0;
    sync_n_nxt = sync_n_r;
    strobe_n_nxt = strobe_n_r;
    reset_n_nxt = reset_n_r;
    unique case (st_r)
      ST_RST_LOW: begin
        reset_n_nxt = 1'b0;
        if (cnt_r >= CNT_W'(RST_LOW_CYC - 1)) begin
          reset_n_nxt = 1'b1;
          cnt_nxt = '0;
          st_nxt = ST_RST_WAIT;
        end
      end
      ST_RST_WAIT: begin
        if (cnt_r >= CNT_W'(RST_WAIT_CYC - 1)) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        cnt_nxt = '0;
        if (i_hw_reset) begin
          reset_n_nxt = 1'b0;
          strobe_n_nxt = 1'b1;
          st_nxt = ST_RST_LOW;
        end else if (i_cmd_valid) begin
          cmd_nxt = i_cmd;
          tx_nxt = i_cmd.crc_en ? i_cmd.data : {i_cmd.data[FRAME_BITS-1:0], (WORD_W - FRAME_BITS)'(0)};
          rx_nxt = '0;
          bits_nxt = '0;
          sync_n_nxt = 1'b0;
          strobe_n_nxt = (i_cmd.load != LOAD_TIED);
          st_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_r >= CNT_W'(SYNC_SETUP_CYC - 1)) begin
          st_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (sclk_fall) begin
          bits_nxt = bits_r + BITCNT_W'(1);
        end
        // sample sdo late in the low phase; shift next bit on rising edge
        if (sclk_rise) begin
          rx_nxt = {rx_r[WORD_W-2:0], sdo_sync_r};
          tx_nxt = {tx_r[WORD_W-2:0], 1'b0};
          // stop after the frame's own edges
          if (bits_r == frame_bits) begin
            cnt_nxt = '0;
            // strobe falls ahead of sync rise
            if (cmd_r.load == LOAD_IN_FRAME) begin
              strobe_n_nxt = 1'b0;
            end
            st_nxt = ST_TAIL;
          end
        end
      end
      ST_TAIL: begin
        if ((cmd_r.load == LOAD_IN_FRAME && cnt_r >= CNT_W'(LOAD_BEFORE_CYC - 1)) ||
            (cmd_r.load != LOAD_IN_FRAME && cnt_r >= CNT_W'(SYNC_HOLD_CYC - 1))) begin
          sync_n_nxt = 1'b1;
          strobe_n_nxt = (cmd_r.load != LOAD_TIED);
          rdata_nxt = cmd_r.crc_en ? rx_r : {(WORD_W - FRAME_BITS)'(0), rx_r[FRAME_BITS-1:0]};
          cnt_nxt = '0;
          st_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        if (cmd_r.load == LOAD_AFTER) begin
          if (cnt_r == CNT_W'(LOAD_AFTER_CYC - 1)) begin
            strobe_n_nxt = 1'b0;
          end
          if (cnt_r == CNT_W'(LOAD_AFTER_CYC + LOAD_LOW_CYC - 1)) begin
            strobe_n_nxt = 1'b1;
          end
        end
        if (cnt_r >= gap_need - CNT_W'(1)) begin
          done_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
        sync_n_nxt = 1'b1;
        strobe_n_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= ST_RST_LOW;
      cmd_r <= '0;
      cnt_r <= '0;
      bits_r <= '0;
      tx_r <= '0;
      rx_r <= '0;
      rdata_r <= '0;
      done_r <= 1'b0;
      sync_n_r <= 1'b1;
      strobe_n_r <= 1'b1;
      reset_n_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      cnt_r <= cnt_nxt;
      bits_r <= bits_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
      sync_n_r <= sync_n_nxt;
      strobe_n_r <= strobe_n_nxt;
      reset_n_r <= reset_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_ready = (st_r == ST_IDLE) && !i_hw_reset;
  assign o_done = done_r;
  assign o_rdata = rdata_r;
  assign o_sdi = tx_r[WORD_W-1];
  assign o_sync_n = sync_n_r;
  assign o_output_load_strobe_n = strobe_n_r;
  assign o_reset_n = reset_n_r;

endmodule : dsq_host

// [tb/dsq_host_props.sv]
// checker for host frame sequencing
`timescale 1ns/1ps
module dsq_host_props
  import dsq_pkg::*;
#(
  parameter int RANGE_GAP_CYC = GAP_RANGE_CYC,
  parameter int RST_WAIT_CYC = dsq_pkg::RST_WAIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire dsq_pkg::dsq_cmd_t i_cmd,
  input wire logic o_ready,
  input wire logic o_sclk,
  input wire logic o_sync_n,
  input wire logic o_output_load_strobe_n,
  input wire logic o_reset_n
);
  logic [15:0] hi_r;
  logic [15:0] lo_r;
  logic [15:0] up_r;
  logic [5:0] falls_r;
  logic sclk_r;
  dsq_cmd_t cmd_r;
  dsq_cmd_t prv_r;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // spans saturate so idle after reset never looks short
  always_ff @(posedge i_clk) begin
    sclk_r <= o_sclk;
    if (i_rst) begin
      hi_r <= 16'hFFFF;
      lo_r <= 16'h0;
      up_r <= 16'h0;
      falls_r <= 6'h0;
      cmd_r <= '0;
      prv_r <= '0;
    end else begin
      hi_r <= !o_sync_n ? 16'h0 : hi_r + {15'h0, ~&hi_r};
      lo_r <= o_output_load_strobe_n ? 16'h0 : lo_r + {15'h0, ~&lo_r};
      up_r <= !o_reset_n ? 16'h0 : up_r + {15'h0, ~&up_r};
      falls_r <= o_sync_n ? 6'h0 : falls_r + {5'h0, sclk_r & ~o_sclk};
      if (i_cmd_valid && o_ready) begin
        cmd_r <= i_cmd;
        prv_r <= cmd_r;
      end
    end
  end
  frame_len_a: assert property ($rose(o_sync_n) |-> falls_r == (cmd_r.crc_en ? 6'h20 : 6'h18))
    else $error("frame clock count wrong");
  gap_any_a: assert property ($fell(o_sync_n) |-> hi_r >= GAP_ANY_CYC)
    else $error("idle gap too short");
  gap_code_a: assert property ($fell(o_sync_n) && prv_r.kind == KIND_CODE |-> hi_r >= GAP_CODE_CYC)
    else $error("gap after code write too short");
  gap_range_a: assert property ($fell(o_sync_n) && prv_r.kind == KIND_RANGE |-> hi_r >= RANGE_GAP_CYC)
    else $error("gap after span write too short");
  load_lead_a: assert property ($rose(o_sync_n) && cmd_r.load == LOAD_IN_FRAME |-> lo_r >= LOAD_BEFORE_CYC)
    else $error("strobe too late in frame");
  load_late_a: assert property ($fell(o_output_load_strobe_n) && o_sync_n |-> hi_r >= LOAD_AFTER_CYC)
    else $error("strobe too soon after frame");
  load_width_a: assert property ($rose(o_output_load_strobe_n) |-> lo_r >= LOAD_LOW_CYC)
    else $error("strobe pulse too short");
  rst_wait_a: assert property ($fell(o_sclk) |-> up_r >= RST_WAIT_CYC)
    else $error("clock too soon after reset");
  cover property ($rose(o_sync_n) && cmd_r.crc_en);
  cover property ($fell(o_output_load_strobe_n) && o_sync_n);
  cover property ($fell(o_sync_n) && prv_r.kind == KIND_RANGE);
endmodule : dsq_host_props

bind dsq_host dsq_host_props #(
  .RANGE_GAP_CYC(RANGE_GAP_CYC),
  .RST_WAIT_CYC(RST_WAIT_CYC)
) u_dsq_host_props (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_cmd_valid(i_cmd_valid),
  .i_cmd(i_cmd),
  .o_ready(o_ready),
  .o_sclk(o_sclk),
  .o_sync_n(o_sync_n),
  .o_output_load_strobe_n(o_output_load_strobe_n),
  .o_reset_n(o_reset_n)
);

// [tb/dsq_dev_model.sv]
// behavioural converter serial port
`timescale 1ns/1ps
module dsq_dev_model #(
  parameter logic [31:0] RD_WORD = 32'hC3A5_5A96
) (
  input wire logic i_sclk,
  input wire logic i_sdi,
  input wire logic i_sync_n,
  input wire logic i_load_n,
  output logic o_sdo,
  output logic [31:0] o_word,
  output logic [5:0] o_bits,
  output int o_frames,
  output int o_loads
);
  logic [31:0] sh_r;
  initial begin
    o_sdo = 1'b0;
    o_word = 32'h0;
    o_bits = 6'h0;
    o_frames = 0;
    o_loads = 0;
    sh_r = 32'h0;
  end
  always @(negedge i_sync_n) begin
    o_word <= 32'h0;
    o_bits <= 6'h0;
    sh_r <= RD_WORD;
    o_sdo <= RD_WORD[31];
  end
  always @(negedge i_sclk) begin
    if (!i_sync_n) begin
      o_word <= {o_word[30:0], i_sdi};
      o_bits <= o_bits + 6'h1;
    end
  end
  always @(posedge i_sclk) begin
    if (!i_sync_n) begin
      sh_r <= {sh_r[30:0], 1'b0};
      o_sdo <= sh_r[30];
    end
  end
  always @(negedge i_load_n) o_loads++;
  always @(posedge i_sync_n) begin
    o_sdo <= ~o_sdo;
    o_frames++;
    #1;
    if (!i_load_n) o_loads++;
  end
endmodule : dsq_dev_model

// [tb/testbench.sv]
// self-checking bench for the frame sequencing host
`timescale 1ns/1ps
module testbench;
  import dsq_pkg::*;
  localparam int RG = 100;
  localparam int RW = 50;
  localparam logic [31:0] RD = 32'hC3A5_5A96;
  logic i_clk, i_rst, i_cmd_valid, i_hw_reset, sdo;
  logic ready, done, sclk, sdi, sync_n, load_n, reset_n;
  dsq_cmd_t i_cmd;
  logic [31:0] rdata, word;
  logic [5:0] bits;
  int frames, loads, miscompares, n_tests;
  dsq_host #(.RANGE_GAP_CYC(RG), .RST_WAIT_CYC(RW)) u_dsq_host (
    .i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_hw_reset(i_hw_reset),
    .i_sdo(sdo), .o_ready(ready), .o_done(done), .o_rdata(rdata), .o_sclk(sclk), .o_sdi(sdi),
    .o_sync_n(sync_n), .o_output_load_strobe_n(load_n), .o_reset_n(reset_n));
  dsq_dev_model #(.RD_WORD(RD)) u_dsq_dev_model (
    .i_sclk(sclk), .i_sdi(sdi), .i_sync_n(sync_n), .i_load_n(load_n), .o_sdo(sdo),
    .o_word(word), .o_bits(bits), .o_frames(frames), .o_loads(loads));
  always #10 i_clk = ~i_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  task automatic rst_seq(input int lo);
    int w;
    w = 0;
    for (int k = 0; k < 9 && reset_n !== 1'b0; k++) @(negedge i_clk);
    for (int k = 0; k < 999 && reset_n === 1'b0; k++) begin
      lo++;
      @(negedge i_clk);
    end
    for (int k = 0; k < 999 && ready !== 1'b1; k++) begin
      w++;
      @(negedge i_clk);
    end
    chk({31'h0, reset_n}, 32'h1);
    chk(32'(lo >= RST_LOW_CYC), 32'h1);
    chk({31'h0, ready}, 32'h1);
    chk(32'(w >= RW), 32'h1);
  endtask : rst_seq
  task automatic frame(input logic [31:0] d, input logic crc, input logic slew, input dsq_kind_t kd,
                       input dsq_load_t ld, input int nl);
    int f0;
    int l0;
    int hi;
    int need;
    f0 = frames;
    l0 = loads;
    hi = 0;
    // least idle time the rules ask for after this kind of write
    need = (kd == KIND_CODE) ? GAP_CODE_CYC : ((kd == KIND_RANGE) ? RG : GAP_ANY_CYC);
    for (int k = 0; k < 999 && ready !== 1'b1; k++) @(negedge i_clk);
    i_cmd = '{d, crc, slew, kd, ld};
    i_cmd_valid = 1'b1;
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
    for (int k = 0; k < 9999 && done !== 1'b1; k++) begin
      if (sync_n === 1'b1) hi++;
      @(negedge i_clk);
    end
    chk({31'h0, done}, 32'h1);
    chk(32'(hi >= need), 32'h1);
    chk({26'h0, bits}, crc ? 32'h20 : 32'h18);
    chk(word, crc ? d : {8'h0, d[23:0]});
    chk(rdata, crc ? RD : {8'h0, RD[31:8]});
    chk(32'(frames - f0), 32'h1);
    chk(32'(loads - l0), 32'(nl));
    chk({30'h0, sync_n, sclk}, 32'h3);
  endtask : frame
  task automatic t_reset();
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    rst_seq(3);
  endtask : t_reset
  task automatic t_back_to_back();
    frame(32'hFF12_3456, 1'b0, 1'b0, KIND_OTHER, LOAD_NONE, 0);
    frame(32'h8000_0001, 1'b1, 1'b0, KIND_CODE, LOAD_IN_FRAME, 1);
    frame(32'h0000_0001, 1'b0, 1'b0, KIND_OTHER, LOAD_NONE, 0);
  endtask : t_back_to_back
  task automatic t_range_after();
    frame(32'h0004_000F, 1'b1, 1'b1, KIND_RANGE, LOAD_AFTER, 1);
    frame(32'h0000_0002, 1'b0, 1'b0, KIND_OTHER, LOAD_AFTER, 1);
  endtask : t_range_after
  task automatic t_tied();
    frame(32'h00FF_FF00, 1'b0, 1'b0, KIND_CODE, LOAD_TIED, 2);
    frame(32'h007F_FFFE, 1'b0, 1'b1, KIND_OTHER, LOAD_NONE, 0);
    chk({31'h0, load_n}, 32'h1);
  endtask : t_tied
  task automatic t_hw_reset();
    i_hw_reset = 1'b1;
    @(negedge i_clk);
    i_hw_reset = 1'b0;
    rst_seq(0);
    frame(32'h00C0_FFEE, 1'b1, 1'b0, KIND_OTHER, LOAD_NONE, 0);
  endtask : t_hw_reset
  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    i_cmd_valid = 1'b0;
    i_hw_reset = 1'b0;
    i_cmd = '0;
    t_reset();
    t_back_to_back();
    t_range_after();
    t_tied();
    t_hw_reset();
    test_done();
  end
  // whole run is near 3000 clocks
  initial begin
    #1000000;
    miscompares++;
    test_done();
  end
endmodule : testbench
